/* design/dts_pkg.sv */
/*
 * Package for the die temperature status block: register field positions,
 * reset values, feature-identification bits and carrier structs.
 * Assumes a core-side register port that addresses the two registers
 * by select line, with no public bus around it.
 */
// Behaviour
// - Feature bits 22 and 29 report presence
// - Leaf 06H reports sensor, threshold count
// - Reading saturates at activation point
// - Status bit 0 mirrors hot output
// - Bit 1 sticky hot log
// - Bit 2 shows gated external hot or reduction
// - Bit 3 latches external events, gated hot
// - Bit 4 mirrors critical detector
// - Bit 5 sticky critical log
// - Bits 6,7 first threshold status and log
// - Bits 8,9 second threshold status and log
// - Bits 22:16 degrees below activation
// - Bits 30:27 report sensor resolution
// - Bit 31 marks reading valid
// - Control bit 0 enables hot-going interrupt
// - Control bit 1 enables cool-going interrupt
// - Bits 2,3 enable external event interrupts
// - Bit 4 enables critical interrupt
// - Threshold fields 14:8 and 22:16
// - Threshold enables 15,23 active low, both ways
package dts_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int FEAT_PRESENT_BIT = 22;
    localparam int FEAT_THROTTLE_BIT = 29;
    localparam logic [7:0] LEAF_THERMAL = 8'h06;
    localparam int LEAF_SENSOR_BIT = 0;
    localparam int LEAF_NTHR_LO = 0;
    localparam logic [3:0] NUM_THRESHOLDS = 4'h2;

    ////////////////////////////////////////////////////////////////////////
    localparam int ST_HOT = 0;
    localparam int ST_HOT_LOG = 1;
    localparam int ST_EXT = 2;
    localparam int ST_EXT_LOG = 3;
    localparam int ST_CRIT = 4;
    localparam int ST_CRIT_LOG = 5;
    localparam int ST_THR1 = 6;
    localparam int ST_THR1_LOG = 7;
    localparam int ST_THR2 = 8;
    localparam int ST_THR2_LOG = 9;
    localparam int ST_READ_LO = 16;
    localparam int ST_RES_LO = 27;
    localparam int ST_VALID = 31;

    ////////////////////////////////////////////////////////////////////////
    localparam int IC_HIGH_EN = 0;
    localparam int IC_LOW_EN = 1;
    localparam int IC_EXTHOT_EN = 2;
    localparam int IC_FPR_EN = 3;
    localparam int IC_CRIT_EN = 4;
    localparam int IC_THR1_LO = 8;
    localparam int IC_THR1_DIS = 15;
    localparam int IC_THR2_LO = 16;
    localparam int IC_THR2_DIS = 23;
    localparam logic [31:0] IC_RESET = 32'h0000_0000;
    localparam logic [3:0] RESOLUTION_DEG = 4'h1;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic       hot;
        logic       extHot;
        logic       forceReduce;
        logic       critical;
        logic       valid;
        logic [6:0] reading;
    } dts_sense_s;

    typedef struct packed {
        logic        wrStatus;
        logic        wrControl;
        logic [31:0] wrData;
    } dts_regwr_s;

endpackage

/* design/dts_sync_reg.sv */
/*
 * Small register stage holding the registered copy of the status word.
 * Assumes the parent computes the next words combinationally.
 */
`timescale 1ns/1ps
module dts_sync_reg #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] dataD,
    output logic      [W-1:0] dataQ
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dataQ <= '0;
        else
            dataQ <= dataD;
    end
endmodule

/* design/dts_thermal_status.sv */
/*
 * Thermal status and interrupt logic around the on-die sensor.
 * Holds the status and interrupt-control registers, the feature words
 * and the interrupt request. Assumes sensor inputs are synchronous to clk
 * and that register writes arrive as one-cycle strobes.
 */
`timescale 1ns/1ps
module dts_thermal_status #(
    parameter logic [3:0] RESOLUTION = dts_pkg::RESOLUTION_DEG
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Sensor and platform
    input  dts_pkg::dts_sense_s     sense,
    input  wire logic               bidirHotEn,
    input  wire logic               throttlePresent,
    // Register writes
    input  dts_pkg::dts_regwr_s     regWr,
    // Feature query leaf select
    input  wire logic [7:0]         featLeaf,
    // Read side
    output logic [31:0]             statusRd,
    output logic [31:0]             controlRd,
    output logic [31:0]             featEdx,
    output logic [31:0]             leafEax,
    output logic [31:0]             leafEbx,
    output logic                    thermIrq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] thrField(input logic [31:0] c, input int lo);
        thrField = c[lo +: 7];
    endfunction

    logic [31:0] ctrlQ, ctrlD;
    logic [2:0]  logQ, logD;          // hot, ext, crit logs
    logic [1:0]  thrLogQ, thrLogD;
    logic [1:0]  thrStQ, thrStD;
    logic        hotQ, critQ, extQ, fprQ;
    logic        irqD;
    logic [6:0]  readSat;
    logic        extEvt;
    logic [31:0] statusD, featD, eaxD, ebxD;

    ////////////////////////////////////////////////////////////////////////
    // Readings below zero cannot be encoded, so the field floors at the activation point
    assign readSat = sense.reading;   // 7-bit unsigned; zero is the hottest code
    assign extEvt  = (sense.extHot & bidirHotEn) | sense.forceReduce;

    always_comb
    begin
        ctrlD = ctrlQ;
        if (regWr.wrControl)
            ctrlD = regWr.wrData & 32'h00ff_ff1f;
        // Lower code means hotter: at-or-above threshold when reading <= threshold
        thrStD[0] = sense.valid & (readSat <= thrField(ctrlQ, dts_pkg::IC_THR1_LO));
        thrStD[1] = sense.valid & (readSat <= thrField(ctrlQ, dts_pkg::IC_THR2_LO));
        logD = logQ;
        thrLogD = thrLogQ;
        if (regWr.wrStatus)
        begin
            // Zero clears, one
            logD[0] = logQ[0] & regWr.wrData[dts_pkg::ST_HOT_LOG];
            logD[1] = logQ[1] & regWr.wrData[dts_pkg::ST_EXT_LOG];
            logD[2] = logQ[2] & regWr.wrData[dts_pkg::ST_CRIT_LOG];
            thrLogD[0] = thrLogQ[0] & regWr.wrData[dts_pkg::ST_THR1_LOG];
            thrLogD[1] = thrLogQ[1] & regWr.wrData[dts_pkg::ST_THR2_LOG];
        end
        // Set wins over a clear in the same cycle
        if (sense.hot)
            logD[0] = 1'b1;
        if (extEvt)
            logD[1] = 1'b1;
        if (sense.critical)
            logD[2] = 1'b1;
        if (thrStD[0])
            thrLogD[0] = 1'b1;
        if (thrStD[1])
            thrLogD[1] = 1'b1;
    end

    always_comb
    begin
        irqD = 1'b0;
        if (ctrlQ[dts_pkg::IC_HIGH_EN] & sense.hot & ~hotQ)
            irqD = 1'b1;
        if (ctrlQ[dts_pkg::IC_LOW_EN] & ~sense.hot & hotQ)
            irqD = 1'b1;
        if (ctrlQ[dts_pkg::IC_EXTHOT_EN] & bidirHotEn & sense.extHot & ~extQ)
            irqD = 1'b1;
        if (ctrlQ[dts_pkg::IC_FPR_EN] & sense.forceReduce & ~fprQ)
            irqD = 1'b1;
        if (ctrlQ[dts_pkg::IC_CRIT_EN] & sense.critical & ~critQ)
            irqD = 1'b1;
        if (~ctrlQ[dts_pkg::IC_THR1_DIS] & (thrStD[0] != thrStQ[0]))
            irqD = 1'b1;
        if (~ctrlQ[dts_pkg::IC_THR2_DIS] & (thrStD[1] != thrStQ[1]))
            irqD = 1'b1;
    end

    always_comb
    begin
        statusD = 32'h0000_0000;
        statusD[dts_pkg::ST_HOT]      = sense.hot;
        statusD[dts_pkg::ST_HOT_LOG]  = logD[0];
        statusD[dts_pkg::ST_EXT]      = extEvt;
        statusD[dts_pkg::ST_EXT_LOG]  = logD[1];
        statusD[dts_pkg::ST_CRIT]     = sense.critical;
        statusD[dts_pkg::ST_CRIT_LOG] = logD[2];
        statusD[dts_pkg::ST_THR1]     = thrStD[0];
        statusD[dts_pkg::ST_THR1_LOG] = thrLogD[0];
        statusD[dts_pkg::ST_THR2]     = thrStD[1];
        statusD[dts_pkg::ST_THR2_LOG] = thrLogD[1];
        statusD[dts_pkg::ST_READ_LO +: 7] = readSat;
        statusD[dts_pkg::ST_RES_LO +: 4]  = RESOLUTION;
        statusD[dts_pkg::ST_VALID]    = sense.valid;
        featD = 32'h0000_0000;
        featD[dts_pkg::FEAT_PRESENT_BIT]  = 1'b1;
        featD[dts_pkg::FEAT_THROTTLE_BIT] = throttlePresent;
        eaxD = 32'h0000_0000;
        ebxD = 32'h0000_0000;
        if (featLeaf == dts_pkg::LEAF_THERMAL)
        begin
            eaxD[dts_pkg::LEAF_SENSOR_BIT] = 1'b1;
            ebxD[dts_pkg::LEAF_NTHR_LO +: 4] = dts_pkg::NUM_THRESHOLDS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status writes never reach the read-only fields; they change only the logs held here
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrlQ    <= dts_pkg::IC_RESET;
            logQ     <= 3'h0;
            thrLogQ  <= 2'h0;
            thrStQ   <= 2'h0;
            hotQ     <= 1'b0;
            critQ    <= 1'b0;
            extQ     <= 1'b0;
            fprQ     <= 1'b0;
            thermIrq <= 1'b0;
            featEdx  <= 32'h0000_0000;
            leafEax  <= 32'h0000_0000;
            leafEbx  <= 32'h0000_0000;
            controlRd <= 32'h0000_0000;
        end
        else
        begin
            ctrlQ    <= ctrlD;
            logQ     <= logD;
            thrLogQ  <= thrLogD;
            thrStQ   <= thrStD;
            hotQ     <= sense.hot;
            critQ    <= sense.critical;
            extQ     <= sense.extHot;
            fprQ     <= sense.forceReduce;
            thermIrq <= irqD;
            featEdx  <= featD;
            leafEax  <= eaxD;
            leafEbx  <= ebxD;
            controlRd <= ctrlD;
        end
    end

    // Status word kept in its own stage so reads always see a registered copy
    dts_sync_reg #(.W(32)) uStatus (
        .clk   (clk),
        .rst_n (rst_n),
        .dataD (statusD),
        .dataQ (statusRd)
    );

    ////////////////////////////////////////////////////////////////////////
    property p_hot_log;
        @(posedge clk) disable iff (!rst_n)
        sense.hot |=> statusRd[dts_pkg::ST_HOT_LOG];
    endproperty
    a_hot_log: assert property (p_hot_log) else $error("hot log not set");

    property p_hot_mirror;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> statusRd[dts_pkg::ST_HOT] == $past(sense.hot);
    endproperty
    a_hot_mirror: assert property (p_hot_mirror) else $error("hot mirror wrong");

    property p_crit_log;
        @(posedge clk) disable iff (!rst_n)
        sense.critical |=> statusRd[dts_pkg::ST_CRIT_LOG];
    endproperty
    a_crit_log: assert property (p_crit_log) else $error("critical log not set");

    property p_log_hold;
        @(posedge clk) disable iff (!rst_n)
        (statusRd[dts_pkg::ST_CRIT_LOG] && !regWr.wrStatus) |=> statusRd[dts_pkg::ST_CRIT_LOG];
    endproperty
    a_log_hold: assert property (p_log_hold) else $error("critical log dropped");

    property p_ext_gate;
        @(posedge clk) disable iff (!rst_n)
        (sense.extHot && !bidirHotEn && !sense.forceReduce) |=> !statusRd[dts_pkg::ST_EXT];
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("ungated external hot");

    property p_crit_irq;
        @(posedge clk) disable iff (!rst_n)
        (ctrlQ[dts_pkg::IC_CRIT_EN] && sense.critical && !critQ) |=> thermIrq;
    endproperty
    a_crit_irq: assert property (p_crit_irq) else $error("critical irq missing");

    property p_high_irq;
        @(posedge clk) disable iff (!rst_n)
        (ctrlQ[dts_pkg::IC_HIGH_EN] && $rose(sense.hot)) |=> thermIrq;
    endproperty
    a_high_irq: assert property (p_high_irq) else $error("high irq missing");

    property p_ctrl_wr;
        @(posedge clk) disable iff (!rst_n)
        regWr.wrControl |=> controlRd[dts_pkg::IC_THR1_LO +: 7]
            == $past(regWr.wrData[dts_pkg::IC_THR1_LO +: 7]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("threshold not stored");

    property p_crit_mirror;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_CRIT] == $past(sense.critical);
    endproperty
    a_crit_mirror: assert property (p_crit_mirror) else $error("critical bit wrong");

    // Bidirectional gating applies to the live bit as well as the log
    property p_ext_mirror;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_EXT]
            == (($past(sense.extHot) && $past(bidirHotEn)) || $past(sense.forceReduce));
    endproperty
    a_ext_mirror: assert property (p_ext_mirror) else $error("external bit wrong");

    property p_read_field;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_READ_LO +: 7] == $past(sense.reading);
    endproperty
    a_read_field: assert property (p_read_field) else $error("reading field wrong");

    property p_valid_bit;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_VALID] == $past(sense.valid);
    endproperty
    a_valid_bit: assert property (p_valid_bit) else $error("valid bit wrong");

    property p_resolution;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_RES_LO +: 4] == RESOLUTION;
    endproperty
    a_resolution: assert property (p_resolution) else $error("resolution wrong");

    property p_low_irq;
        @(posedge clk) disable iff (!rst_n)
        (ctrlQ[dts_pkg::IC_LOW_EN] && $fell(sense.hot)) |=> thermIrq;
    endproperty
    a_low_irq: assert property (p_low_irq) else $error("low irq missing");

    property p_fpr_irq;
        @(posedge clk) disable iff (!rst_n)
        (ctrlQ[dts_pkg::IC_FPR_EN] && $rose(sense.forceReduce)) |=> thermIrq;
    endproperty
    a_fpr_irq: assert property (p_fpr_irq) else $error("reduction irq missing");

    // A crossing shows as a change of the status bit; the enable that counts
    // is the one in force on the cycle the comparison was made
    sequence s_thr1_cross;
        $changed(statusRd[dts_pkg::ST_THR1]) && !$past(ctrlQ[dts_pkg::IC_THR1_DIS]);
    endsequence

    sequence s_thr2_cross;
        $changed(statusRd[dts_pkg::ST_THR2]) && !$past(ctrlQ[dts_pkg::IC_THR2_DIS]);
    endsequence

    property p_thr1_irq;
        @(posedge clk) disable iff (!rst_n)
        s_thr1_cross |-> thermIrq;
    endproperty
    a_thr1_irq: assert property (p_thr1_irq) else $error("first irq missing");

    property p_thr2_irq;
        @(posedge clk) disable iff (!rst_n)
        s_thr2_cross |-> thermIrq;
    endproperty
    a_thr2_irq: assert property (p_thr2_irq) else $error("second irq missing");

    property p_thr1_status;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_THR1] == ($past(sense.valid)
            && ($past(sense.reading) <= $past(ctrlQ[dts_pkg::IC_THR1_LO +: 7])));
    endproperty
    a_thr1_status: assert property (p_thr1_status) else $error("first status wrong");

    property p_thr2_status;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> statusRd[dts_pkg::ST_THR2] == ($past(sense.valid)
            && ($past(sense.reading) <= $past(ctrlQ[dts_pkg::IC_THR2_LO +: 7])));
    endproperty
    a_thr2_status: assert property (p_thr2_status) else $error("second status wrong");

endmodule

/* test/test_dts_thermal_status.sv */
/*
 * Self-checking bench for the die temperature status block.
 * Assumes the register write strobes and sensor levels are driven here,
 * synchronous to clk, with no partner model and no bus around the block.
 */
`timescale 1ns/1ps
module test_dts_thermal_status;

    // Non-default resolution, so a hard-wired field would show
    localparam logic [3:0] RES = 4'h3;
    logic                clk;
    logic                rst_n;
    dts_pkg::dts_sense_s sense;
    logic                bidirHotEn;
    logic                throttlePresent;
    dts_pkg::dts_regwr_s regWr;
    logic [7:0]          featLeaf;
    logic [31:0]         statusRd;
    logic [31:0]         controlRd;
    logic [31:0]         featEdx;
    logic [31:0]         leafEax;
    logic [31:0]         leafEbx;
    logic                thermIrq;
    int                  errors;
    int                  testsRun;

    dts_thermal_status #(.RESOLUTION(RES)) DUT (
        .clk(clk), .rst_n(rst_n), .sense(sense), .bidirHotEn(bidirHotEn),
        .throttlePresent(throttlePresent), .regWr(regWr), .featLeaf(featLeaf),
        .statusRd(statusRd), .controlRd(controlRd), .featEdx(featEdx),
        .leafEax(leafEax), .leafEbx(leafEbx), .thermIrq(thermIrq)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks made: %0d, mismatches: %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun = testsRun + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe held for exactly one taken edge
    task automatic wr(input logic toStatus, input logic [31:0] data);
        @(posedge clk);
        regWr <= '{wrStatus: toStatus, wrControl: !toStatus, wrData: data};
        @(posedge clk);
        regWr <= '{wrStatus: 1'b0, wrControl: 1'b0, wrData: data};
        #1;
    endtask

    // Pulses counted in a fixed window, so a stuck request also shows
    task automatic expect_irq(input int expCount);
        int n;
        n = 0;
        repeat (4)
        begin
            @(posedge clk);
            #1;
            if (thermIrq !== 1'b0)
                n = n + 1;
        end
        chk(32'(n), 32'(expCount));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_ident();
        @(posedge clk);
        featLeaf <= 8'h06;
        repeat (2) @(posedge clk);
        #1;
        chk(statusRd, {1'b0, RES, 27'h0});
        chk(controlRd, dts_pkg::IC_RESET);
        chk(featEdx, 32'h2040_0000);
        chk(leafEax, 32'h0000_0001);
        chk(leafEbx, 32'h0000_0002);
        @(posedge clk);
        throttlePresent <= 1'b0;
        featLeaf <= 8'h05;
        repeat (2) @(posedge clk);
        #1;
        chk(featEdx, 32'h0040_0000);
        chk(leafEax | leafEbx, 32'h0000_0000);
    endtask

    task automatic t_control();
        wr(1'b0, 32'hffff_ffff);
        chk(controlRd, 32'h00ff_ff1f);
        wr(1'b0, 32'h0000_0000);
        chk(controlRd, 32'h0000_0000);
    endtask

    task automatic t_hot();
        wr(1'b0, 32'h0000_0003);
        @(posedge clk);
        sense.hot <= 1'b1;
        expect_irq(1);
        chk(statusRd & 32'h3, 32'h3);
        @(posedge clk);
        sense.hot <= 1'b0;
        expect_irq(1);
        wr(1'b1, 32'hffff_ffff);
        chk(statusRd & 32'h3, 32'h2);
        wr(1'b1, 32'h0000_0000);
        chk(statusRd & 32'h3, 32'h0);
    endtask

    task automatic t_external();
        wr(1'b0, 32'h0000_000c);
        @(posedge clk);
        sense.extHot <= 1'b1;
        expect_irq(0);
        chk(statusRd & 32'h8, 32'h0);
        @(posedge clk);
        sense.extHot <= 1'b0;
        bidirHotEn <= 1'b1;
        repeat (2) @(posedge clk);
        sense.extHot <= 1'b1;
        expect_irq(1);
        chk(statusRd & 32'hc, 32'hc);
        @(posedge clk);
        sense.extHot <= 1'b0;
        wr(1'b1, 32'h0000_0000);
        chk(statusRd & 32'hc, 32'h0);
        @(posedge clk);
        sense.forceReduce <= 1'b1;
        expect_irq(1);
        @(posedge clk);
        sense.forceReduce <= 1'b0;
        expect_irq(0);
        chk(statusRd & 32'hc, 32'h8);
        wr(1'b1, 32'h0000_0000);
    endtask

    task automatic t_critical();
        wr(1'b0, 32'h0000_0000);
        @(posedge clk);
        sense.critical <= 1'b1;
        expect_irq(0);
        chk(statusRd & 32'h30, 32'h30);
        @(posedge clk);
        sense.critical <= 1'b0;
        wr(1'b1, 32'h0000_0000);
        chk(statusRd & 32'h30, 32'h0);
        wr(1'b0, 32'h0000_0010);
        @(posedge clk);
        sense.critical <= 1'b1;
        expect_irq(1);
        @(posedge clk);
        sense.critical <= 1'b0;
        wr(1'b1, 32'h0000_0000);
    endtask

    task automatic t_threshold();
        wr(1'b0, 32'h0000_0000);
        @(posedge clk);
        sense.valid <= 1'b1;
        sense.reading <= 7'h20;
        // Threshold 1 kept clear of the reading; threshold 2 programmed already crossed, its interrupt disabled
        wr(1'b0, 32'h00b0_1000);
        expect_irq(0);
        chk(statusRd & 32'hffff_03c0, {1'b1, RES, 27'h20_0300});
        @(posedge clk);
        sense.reading <= 7'h10;
        expect_irq(1);
        chk(statusRd & 32'hc0, 32'hc0);
        @(posedge clk);
        sense.reading <= 7'h11;
        expect_irq(1);
        chk(statusRd & 32'hc0, 32'h80);
        wr(1'b1, 32'h0000_0000);
        chk(statusRd & 32'hc0, 32'h0);
        wr(1'b0, 32'h0030_0800);
        @(posedge clk);
        sense.reading <= 7'h31;
        expect_irq(1);
        chk(statusRd & 32'h300, 32'h200);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        testsRun = 0;
        rst_n = 1'b0;
        sense = '0;
        bidirHotEn = 1'b0;
        throttlePresent = 1'b1;
        regWr = '0;
        featLeaf = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_ident();
        t_control();
        t_hot();
        t_external();
        t_critical();
        t_threshold();
        give_verdict();
    end

    // Guard against a hang anywhere in the sequence
    initial
    begin
        repeat (20000) @(posedge clk);
        errors = errors + 1;
        give_verdict();
    end

endmodule
